/* File: rtl/rtcsl_pkg.sv */
// Purpose: Shared constants and types of the clock/calendar two-wire slave port
// Assumes: Core clock of 40 MHz; the link clock is the master's serial clock
// Notes: Pointer is five bits wide so reads can roll over at the top of its range
package rtcsl_pkg;

    // Core clock and power-up quiet time
    localparam int unsigned REF_CLK_MHZ = 40;
    localparam int unsigned POWERUP_NS = 1000;
    localparam int unsigned POWERUP_CYCLES = (POWERUP_NS * REF_CLK_MHZ + 999) / 1000;

    // Addressing
    localparam logic [6:0] DEV_ID = 7'h68;
    localparam int unsigned PTR_W = 5;
    localparam logic [PTR_W-1:0] PTR_RESET = 5'h00;
    localparam logic [PTR_W-1:0] PTR_WRAP_RD = 5'h1f;
    localparam logic [PTR_W-1:0] PTR_WRAP_WR = 5'h07;
    localparam int unsigned NUM_REGS = 8;
    localparam logic [7:0] EMPTY_BYTE = 8'h00;

    // Bit positions within a byte frame
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int unsigned RW_BIT = 0;

    typedef logic [NUM_REGS-1:0][7:0] rtcsl_regs_t;

    typedef struct packed {
        logic [PTR_W-1:0] addr;
        logic [7:0] data;
    } rtcsl_wr_t;

    typedef enum logic [2:0] {
        RTCSL_IDLE,
        RTCSL_DEV,
        RTCSL_REG,
        RTCSL_WDATA,
        RTCSL_SEND,
        RTCSL_IGNORE
    } rtcsl_state_t;

endpackage

/* File: rtl/rtcsl_link.sv */
// Purpose: Link-clock side of the slave port: samples the data line on each rising serial clock
// Assumes: Serial clock comes from the master and may stand still between transfers
// Notes: The toggle marks each sampled bit; the bit value is stable until the next rising edge
`timescale 1ns/100ps
module rtcsl_link (
    input wire logic scl_clk,
    input wire logic rst_b,
    input wire logic sda_i,
    output logic bit_val,
    output logic bit_tgl
);

    always_ff @(posedge scl_clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_val <= 1'b0;
            bit_tgl <= 1'b0;
        end else begin
            bit_val <= sda_i;
            bit_tgl <= ~bit_tgl;
        end
    end

endmodule

/* File: rtl/rtcsl_slave.sv */
// Purpose: Two-wire serial slave port of a clock/calendar: framing, addressing, ack, pointer, read buffer
// Assumes: Register contents live outside; writes leave as strobes, reads come from a snapshot of regs_in
// Notes: Open-drain data line: sda_o is held low, sda_oe high pulls the line low
//
// Behaviour
// - Device is slave only; master starts transfers and drives the serial clock.
// - Bytes shift most significant bit first in both directions.
// - Data changes only with clock low; changes with clock high mark START or STOP.
// - Data line stays released after power-up until a transfer needs driving.
// - Watch for START continuously; ignore traffic before it and during power-up.
// - STOP after a read or write returns the port to idle standby.
// - Transmitter releases after eight bits; receiver pulls low on ninth clock.
// - Acknowledge matching slave address, register address and each write data byte.
// - Compare upper seven bits of first byte to 1101000; ack only on match.
// - Address byte bit zero: one means read, zero means write.
// - Pointer clears to zero at power-up for current-address reads.
// - Write is START, address, register, data, STOP; all three bytes acked.
// - Keep sending bytes while master acks; master ends with STOP.
// - Read data comes from the pointer; pointer loads from address and increments.
// - Read pointer rolls from 1Fh to 00h and output continues.
// - Write pointer wraps from 07h back to 00h.
// - At read start, time registers are copied into a holding buffer.
`timescale 1ns/100ps
module rtcsl_slave #(
    parameter int unsigned POWERUP_CYCLES = rtcsl_pkg::POWERUP_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire rtcsl_pkg::rtcsl_regs_t regs_in,
    output logic wr_stb,
    output rtcsl_pkg::rtcsl_wr_t wr,
    output logic snap_stb
);

    localparam int unsigned PU_W = $clog2(POWERUP_CYCLES + 1);

    // Elaboration checks: buffer index, bit counter and wrap points assume these sizes
    if (POWERUP_CYCLES < 1) begin : g_chk_pu
        $error("POWERUP_CYCLES must be at least one");
    end
    if (rtcsl_pkg::NUM_REGS != 8) begin : g_chk_regs
        $error("holding buffer is addressed with three pointer bits and needs eight registers");
    end
    if (rtcsl_pkg::PTR_W < 3) begin : g_chk_ptr_w
        $error("pointer must be at least three bits wide");
    end
    if (rtcsl_pkg::BITS_PER_BYTE != 4'h8) begin : g_chk_bits
        $error("bit counter and transmit select assume eight-bit bytes");
    end
    if (int'(rtcsl_pkg::PTR_WRAP_WR) >= rtcsl_pkg::NUM_REGS) begin : g_chk_wrap
        $error("write wrap point lies beyond the last register");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link-clock side and crossings

    logic bit_val;
    logic bit_tgl;

    rtcsl_link u_link (
        .scl_clk(scl_i),
        .rst_b(rst_b),
        .sda_i(sda_i),
        .bit_val(bit_val),
        .bit_tgl(bit_tgl)
    );

    // The link flop keeps running while ce is low; bits that arrive then are lost
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] tgl_sync;
    logic scl_q;
    logic sda_q;
    logic tgl_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            tgl_sync <= 2'h0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            tgl_q <= 1'b0;
        end else if (ce) begin
            scl_sync <= {scl_sync[0], scl_i};
            sda_sync <= {sda_sync[0], sda_i};
            tgl_sync <= {tgl_sync[0], bit_tgl};
            scl_q <= scl_sync[1];
            sda_q <= sda_sync[1];
            tgl_q <= tgl_sync[1];
        end
    end

    logic start_evt;
    logic stop_evt;
    logic rise_evt;
    logic fall_evt;

    // Data edges with clock high are bus conditions, not data
    assign start_evt = scl_sync[1] && scl_q && sda_q && !sda_sync[1];
    assign stop_evt = scl_sync[1] && scl_q && !sda_q && sda_sync[1];
    assign rise_evt = tgl_sync[1] ^ tgl_q;
    assign fall_evt = scl_q && !scl_sync[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Power-up quiet time

    // STARTs are refused until this count has run out after reset
    logic [PU_W-1:0] pu_cnt;
    logic pu_done;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pu_cnt <= '0;
            pu_done <= 1'b0;
        end else if (ce && !pu_done) begin
            pu_cnt <= pu_cnt + 1'b1;
            pu_done <= (pu_cnt == PU_W'(POWERUP_CYCLES - 1));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Protocol engine

    rtcsl_pkg::rtcsl_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic ack_pend;
    logic rw;
    logic [rtcsl_pkg::PTR_W-1:0] ptr;
    logic [7:0] snap [rtcsl_pkg::NUM_REGS];
    logic [7:0] byte_in;
    logic byte_done;

    // bit_val needs no synchroniser: it has settled long before its toggle arrives
    assign byte_in = {shift[6:0], bit_val};
    assign byte_done = rise_evt && (bitcnt == rtcsl_pkg::BITS_PER_BYTE - 4'h1);

    // Addresses without a register read back as an empty byte
    function automatic logic [7:0] snap_byte(input logic [rtcsl_pkg::PTR_W-1:0] p,
                                             input logic [7:0] buf_in [rtcsl_pkg::NUM_REGS]);
        logic [7:0] r;
        r = rtcsl_pkg::EMPTY_BYTE;
        if (p < rtcsl_pkg::PTR_W'(rtcsl_pkg::NUM_REGS)) begin
            r = buf_in[p[2:0]];
        end
        return r;
    endfunction

    // Bus conditions take priority over bit events; only a master clock moves the engine
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= rtcsl_pkg::RTCSL_IDLE;
            bitcnt <= 4'h0;
            shift <= 8'h00;
            ack_pend <= 1'b0;
            rw <= 1'b0;
        end else if (ce) begin
            if (start_evt && pu_done) begin
                state <= rtcsl_pkg::RTCSL_DEV;
                bitcnt <= 4'h0;
                ack_pend <= 1'b0;
            end else if (stop_evt) begin
                state <= rtcsl_pkg::RTCSL_IDLE;
                bitcnt <= 4'h0;
                ack_pend <= 1'b0;
            end else if (rise_evt && state != rtcsl_pkg::RTCSL_IDLE && state != rtcsl_pkg::RTCSL_IGNORE) begin
                if (bitcnt < rtcsl_pkg::BITS_PER_BYTE) begin
                    shift <= byte_in;
                    bitcnt <= bitcnt + 4'h1;
                    if (byte_done) begin
                        unique case (state)
                            rtcsl_pkg::RTCSL_DEV: begin
                                ack_pend <= (byte_in[7:1] == rtcsl_pkg::DEV_ID);
                                rw <= byte_in[rtcsl_pkg::RW_BIT];
                            end
                            rtcsl_pkg::RTCSL_REG, rtcsl_pkg::RTCSL_WDATA: ack_pend <= 1'b1;
                            rtcsl_pkg::RTCSL_SEND: ack_pend <= 1'b0;
                            default: ack_pend <= 1'b0;
                        endcase
                    end
                end else begin
                    // Ninth clock: acknowledge bit has just been sampled
                    bitcnt <= 4'h0;
                    ack_pend <= 1'b0;
                    unique case (state)
                        rtcsl_pkg::RTCSL_DEV: begin
                            if (!ack_pend) begin
                                state <= rtcsl_pkg::RTCSL_IGNORE;
                            end else if (rw) begin
                                state <= rtcsl_pkg::RTCSL_SEND;
                            end else begin
                                state <= rtcsl_pkg::RTCSL_REG;
                            end
                        end
                        rtcsl_pkg::RTCSL_REG: state <= rtcsl_pkg::RTCSL_WDATA;
                        rtcsl_pkg::RTCSL_WDATA: state <= rtcsl_pkg::RTCSL_WDATA;
                        rtcsl_pkg::RTCSL_SEND: begin
                            // A high level in the acknowledge slot ends the read
                            if (bit_val) begin
                                state <= rtcsl_pkg::RTCSL_IGNORE;
                            end
                        end
                        default: state <= rtcsl_pkg::RTCSL_IGNORE;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pointer, holding buffer and write strobes

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr <= rtcsl_pkg::PTR_RESET;
            wr_stb <= 1'b0;
            wr <= '0;
            snap_stb <= 1'b0;
        end else if (ce) begin
            wr_stb <= 1'b0;
            snap_stb <= 1'b0;
            if (byte_done && !start_evt && !stop_evt) begin
                unique case (state)
                    rtcsl_pkg::RTCSL_DEV: snap_stb <= (byte_in[7:1] == rtcsl_pkg::DEV_ID) && byte_in[0];
                    rtcsl_pkg::RTCSL_REG: ptr <= byte_in[rtcsl_pkg::PTR_W-1:0];
                    rtcsl_pkg::RTCSL_WDATA: begin
                        // Bytes for addresses without a register are acknowledged but dropped
                        if (ptr <= rtcsl_pkg::PTR_WRAP_WR) begin
                            wr_stb <= 1'b1;
                            wr.addr <= ptr;
                            wr.data <= byte_in;
                        end
                        ptr <= (ptr >= rtcsl_pkg::PTR_WRAP_WR) ? rtcsl_pkg::PTR_RESET : ptr + 1'b1;
                    end
                    // Moves on at the eighth bit of every sent byte, the last one too
                    rtcsl_pkg::RTCSL_SEND: begin
                        ptr <= (ptr == rtcsl_pkg::PTR_WRAP_RD) ? rtcsl_pkg::PTR_RESET : ptr + 1'b1;
                    end
                    default: ptr <= ptr;
                endcase
            end
        end
    end

    // Snapshot of all registers on a read address match
    generate
        for (genvar i = 0; i < rtcsl_pkg::NUM_REGS; i++) begin : g_snap
            always_ff @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    snap[i] <= 8'h00;
                end else if (ce && byte_done && state == rtcsl_pkg::RTCSL_DEV && !start_evt && !stop_evt
                             && byte_in[7:1] == rtcsl_pkg::DEV_ID && byte_in[0]) begin
                    snap[i] <= regs_in[i];
                end
            end
        end
    endgenerate

    // Transmit byte is loaded at each ack clock of a read, from the current pointer
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx <= 8'h00;
        end else if (ce && rise_evt && bitcnt == rtcsl_pkg::BITS_PER_BYTE) begin
            tx <= snap_byte(ptr, snap);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data line drive, changed after the clock has fallen and released at START or STOP

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sda_o <= 1'b0;
            sda_oe <= 1'b0;
        end else if (ce) begin
            if (start_evt || stop_evt) begin
                sda_oe <= 1'b0;
            // Drive changes about three core clocks after the fall, well inside the low phase
            end else if (fall_evt) begin
                if (bitcnt == rtcsl_pkg::BITS_PER_BYTE) begin
                    sda_oe <= ack_pend;
                end else if (state == rtcsl_pkg::RTCSL_SEND) begin
                    sda_oe <= ~tx[3'h7 - bitcnt[2:0]];
                end else begin
                    sda_oe <= 1'b0;
                end
            end
        end
    end

endmodule

/* File: sim/rtcsl_master.sv */
// Purpose: Behavioural two-wire bus master for the slave port
// Assumes: Data line has a pull-up; m_oe high pulls it low
// Notes: 160 ns bit period; clock stands high between frames
`timescale 1ns/100ps
module rtcsl_master (
    output logic scl,
    output logic m_oe,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        m_oe = 1'b0;
    end
    // Long low phase leaves room for the slave's synchronised reply
    task automatic start();
        #20 m_oe = 1'b0;
        #90 scl = 1'b1;
        #80 m_oe = 1'b1;
        #80 scl = 1'b0;
    endtask
    task automatic stop();
        #20 m_oe = 1'b1;
        #90 scl = 1'b1;
        #80 m_oe = 1'b0;
        #80;
    endtask
    // Nine clocks, MSB first; bit 0 is the acknowledge slot
    task automatic xb(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            #20 m_oe = ~d[i];
            #90 scl = 1'b1;
            q[i] = sda;
            #50 scl = 1'b0;
        end
    endtask
endmodule

/* File: sim/rtcsl_slave_props.sv */
// Purpose: Port checks of the two-wire slave port
// Assumes: Core clock domain; bus lines seen as raw levels
// Notes: Bound into every slave instance
`timescale 1ns/100ps
module rtcsl_slave_props #(
    parameter int unsigned POWERUP_CYCLES = rtcsl_pkg::POWERUP_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire rtcsl_pkg::rtcsl_regs_t regs_in,
    input wire logic wr_stb,
    input wire rtcsl_pkg::rtcsl_wr_t wr,
    input wire logic snap_stb
);
    logic [15:0] quiet_cnt;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            quiet_cnt <= 16'h0000;
        end else if (quiet_cnt < 16'(POWERUP_CYCLES)) begin
            quiet_cnt <= quiet_cnt + 16'h0001;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_quiet_powerup: assert property ((quiet_cnt < 16'(POWERUP_CYCLES)) |-> !sda_oe && !wr_stb && !snap_stb)
        else $error("port active in power-up quiet time");
    a_open_drain: assert property (sda_o == 1'b0)
        else $error("data line driven high");
    a_wr_pulse: assert property (wr_stb |=> !wr_stb)
        else $error("write strobe longer than one cycle");
    a_snap_pulse: assert property (snap_stb |=> !snap_stb)
        else $error("snapshot strobe longer than one cycle");
    a_wr_range: assert property (wr_stb |-> wr.addr <= 5'h07)
        else $error("write beyond last register");
    a_wr_acked: assert property (wr_stb |-> !sda_oe ##[1:8] sda_oe)
        else $error("write byte not acknowledged");
    a_snap_acked: assert property (snap_stb |-> !sda_oe ##[1:8] sda_oe)
        else $error("read address not acknowledged");
    a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl_i)
        else $error("data line taken while clock high");
    a_oe_hold_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
        else $error("data drive changed while clock high");
    cover property (wr_stb);
    cover property (snap_stb);
    cover property ($rose(sda_oe));
endmodule
bind rtcsl_slave rtcsl_slave_props #(.POWERUP_CYCLES(POWERUP_CYCLES)) u_props (.ref_clk, .rst_b, .ce, .scl_i,
    .sda_i, .sda_o, .sda_oe, .regs_in, .wr_stb, .wr, .snap_stb);

/* File: sim/tb.sv */
// Purpose: Self-checking bench of the two-wire slave port
// Assumes: Open-drain line with pull-up; master model on the far side
// Notes: Short power-up quiet time keeps the run brief
`timescale 1ns/100ps
module tb;
    localparam int unsigned PU = 20;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic scl, m_oe, sda, sda_o, sda_oe, wr_stb, snap_stb;
    logic [8:0] q;
    rtcsl_pkg::rtcsl_regs_t regs_in = {8'h81, 8'h26, 8'h05, 8'h14, 8'h03, 8'h12, 8'h59, 8'h30};
    rtcsl_pkg::rtcsl_wr_t wr;
    rtcsl_pkg::rtcsl_wr_t wq[$];
    int snaps = 0;
    int miscompares = 0;
    int n_compared = 0;
    always #12.5 ref_clk = ~ref_clk;
    assign sda = ~m_oe & (sda_oe ? sda_o : 1'b1);
    rtcsl_slave #(.POWERUP_CYCLES(PU)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .regs_in(regs_in), .wr_stb(wr_stb), .wr(wr),
        .snap_stb(snap_stb));
    rtcsl_master m (.scl(scl), .m_oe(m_oe), .sda(sda));
    always @(posedge ref_clk) begin
        if (wr_stb === 1'b1) wq.push_back(wr);
        if (snap_stb === 1'b1) snaps++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [12:0] g, input logic [12:0] e);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wb(input logic [7:0] d, input logic ack);
        m.xb({d, 1'b1}, q);
        chk({12'h000, q[0]}, {12'h000, ~ack});
    endtask
    task automatic rb(input logic [7:0] e, input logic more);
        m.xb({8'hff, ~more}, q);
        chk({5'h00, q[8:1]}, {5'h00, e});
    endtask
    task automatic print_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_quiet();
        m.start();
        wb(8'hd0, 1'b0);
        m.stop();
        repeat (PU) @(negedge ref_clk);
    endtask
    task automatic t_cur();
        m.start();
        wb(8'hd1, 1'b1);
        rb(regs_in[0], 1'b1);
        rb(regs_in[1], 1'b0);
        m.stop();
    endtask
    task automatic t_write();
        m.start();
        wb(8'hd0, 1'b1);
        wb(8'h06, 1'b1);
        wb(8'ha5, 1'b1);
        wb(8'h3c, 1'b1);
        wb(8'h5a, 1'b1);
        m.stop();
        chk(13'(wq.size()), 13'h0003);
        chk(wq[0], {5'h06, 8'ha5});
        chk(wq[1], {5'h07, 8'h3c});
        chk(wq[2], {5'h00, 8'h5a});
    endtask
    task automatic t_mismatch();
        logic [7:0] bad [2] = '{8'hd2, 8'h50};
        for (int i = 0; i < 2; i++) begin
            m.start();
            wb(bad[i], 1'b0);
            wb(8'h00, 1'b0);
            m.stop();
        end
        // Register address without a register: bytes acked, nothing written
        m.start();
        wb(8'hd0, 1'b1);
        wb(8'h12, 1'b1);
        wb(8'h77, 1'b1);
        m.stop();
        chk(13'(wq.size()), 13'h0003);
    endtask
    task automatic t_freeze();
        @(negedge ref_clk) ce = 1'b0;
        m.start();
        wb(8'hd0, 1'b0);
        @(negedge ref_clk) ce = 1'b1;
        m.stop();
    endtask
    task automatic t_read(input logic [4:0] a, input int n);
        rtcsl_pkg::rtcsl_regs_t exp;
        int s0;
        exp = regs_in;
        s0 = snaps;
        m.start();
        wb(8'hd0, 1'b1);
        wb({3'h0, a}, 1'b1);
        m.start();
        wb(8'hd1, 1'b1);
        // Clock registers move on after the snapshot; reads must not see it
        @(negedge ref_clk) regs_in = ~regs_in;
        for (int i = 0; i < n; i++) begin
            rb((a <= 5'h07) ? exp[a[2:0]] : rtcsl_pkg::EMPTY_BYTE, i < n - 1);
            a = a + 5'h01;
        end
        m.stop();
        chk(13'(snaps - s0), 13'h0001);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(negedge ref_clk);
        rst_b <= 1'b1;
        t_quiet();
        t_cur();
        t_freeze();
        t_write();
        t_mismatch();
        t_read(5'h05, 4);
        t_read(5'h1e, 4);
        print_verdict();
    end
    initial begin
        #300000;
        miscompares++;
        print_verdict();
    end
endmodule
